// [pdc_compare.sv]
// Purpose: time base and three duty-cycle compare units
// Assumes: one instruction cycle = four clock phases, Avalon-MM slave
// Notes:   override forces pins after dead-time shaping
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module pdc_compare
	import pdc_pkg::*;
#(
	parameter int NCH = PDC_NCH
) (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic [5:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	output logic [31:0]      o_readdata,
	output logic             o_waitrequest,
	output logic [5:0]       o_pwm
);
	pdc_bus_t               st_q;
	logic [PDC_DW-1:0]      buf_q [NCH];
	logic [PDC_DW-1:0]      act_q [NCH];
	logic [PDC_TW-1:0]      per_buf_q;
	logic [PDC_TW-1:0]      per_q;
	logic [PDC_TW-1:0]      cnt_q;
	logic [1:0]             ph_q;
	logic [2:0]             pre_q;
	logic [5:0]             ctrl_q;
	logic [5:0]             ovr_q;
	logic [7:0]             dead_q;
	logic [NCH-1:0]         act_out_q;
	logic [NCH-1:0]         match;
	logic [31:0]            rd_d;
	logic [31:0]            rd_q;
	logic                   wait_q;
	logic                   wr_go;
	logic                   tick;
	logic                   wrap;
	logic                   ps_1to1;
	logic [2:0]             pre_lim;
	logic [5:0]             pwm_raw;

	assign o_readdata    = rd_q;
	assign o_waitrequest = wait_q;
	assign ps_1to1 = (ctrl_q[PDC_C_PS+:2] == PDC_PS_1TO1);
	// prescale 1:1, 1:4 and 1:8 as instruction cycles per count minus one
	always_comb begin
		case (ctrl_q[PDC_C_PS+:2])
			2'h0:    pre_lim = 3'h0;
			2'h1:    pre_lim = 3'h3;
			2'h2:    pre_lim = 3'h7;
			default: pre_lim = 3'h7;
		endcase
	end
	// >= lets a shorter prescale take hold at once after a longer one
	assign tick = ctrl_q[PDC_C_EN] && (ph_q == 2'h3)
		&& (pre_q >= pre_lim);
	assign wrap = tick && (cnt_q == per_q);

	// bus slave: two wait cycles then the answer in DONE
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			st_q <= PDC_S_IDLE;
		end else begin
			case (st_q)
				PDC_S_IDLE: if (i_read || i_write) st_q <= PDC_S_RESP;
				PDC_S_RESP: st_q <= PDC_S_DONE;
				PDC_S_DONE: st_q <= PDC_S_IDLE;
				default:    st_q <= PDC_S_IDLE;
			endcase
		end
	end
	assign wr_go = (st_q == PDC_S_RESP) && i_write;

	// waitrequest from a flop of its own: low only while the state
	// register sits in DONE, so the pin carries no decode glitch
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			wait_q <= 1'b1;
		else
			wait_q <= (st_q != PDC_S_RESP);
	end

	// read mux; unmapped reads return zero
	always_comb begin
		rd_d = PDC_UNMAPPED;
		case (i_address)
			PDC_A_D0L:  rd_d = {24'h0, buf_q[0][7:0]};
			PDC_A_D0H:  rd_d = {26'h0, buf_q[0][13:8]};
			PDC_A_D1L:  rd_d = {24'h0, buf_q[1][7:0]};
			PDC_A_D1H:  rd_d = {26'h0, buf_q[1][13:8]};
			PDC_A_D2L:  rd_d = {24'h0, buf_q[2][7:0]};
			PDC_A_D2H:  rd_d = {26'h0, buf_q[2][13:8]};
			PDC_A_PERL: rd_d = {24'h0, per_buf_q[7:0]};
			PDC_A_PERH: rd_d = {28'h0, per_buf_q[11:8]};
			PDC_A_CTRL: rd_d = {26'h0, ctrl_q};
			PDC_A_OVR:  rd_d = {26'h0, ovr_q};
			PDC_A_STAT: rd_d = 32'({act_out_q, ph_q, cnt_q});
			PDC_A_DEAD: rd_d = {24'h0, dead_q};
			default:    rd_d = PDC_UNMAPPED;
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			rd_q <= 32'h0;
		else if (st_q == PDC_S_RESP && i_read)
			rd_q <= rd_d;
	end

	// control-type registers
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			per_buf_q <= PDC_PER_RST;
			ctrl_q    <= 6'h00;
			ovr_q     <= 6'h00;
			dead_q    <= PDC_DEAD_RST;
		end else if (wr_go) begin
			case (i_address)
				PDC_A_PERL: per_buf_q[7:0]  <= i_writedata[7:0];
				PDC_A_PERH: per_buf_q[11:8] <= i_writedata[3:0];
				PDC_A_CTRL: ctrl_q <= i_writedata[5:0];
				PDC_A_OVR:  ovr_q  <= i_writedata[5:0];
				PDC_A_DEAD: dead_q <= i_writedata[7:0];
				default:    ;
			endcase
		end
	end

	// phase and prescale counters; phase 0..3 stands for Q1..Q4
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			ph_q  <= 2'h0;
			pre_q <= 3'h0;
		end else begin
			ph_q <= ph_q + 2'h1;
			if (ph_q == 2'h3)
				pre_q <= tick ? 3'h0 : pre_q + 3'h1;
		end
	end

	// time base; free-running and single-shot modes run alike here
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			cnt_q <= 12'h000;
			per_q <= PDC_PER_RST;
		end else if (!ctrl_q[PDC_C_EN]) begin
			per_q <= per_buf_q;
		end else if (wrap) begin
			cnt_q <= 12'h000;
			per_q <= per_buf_q;
		end else if (tick) begin
			cnt_q <= cnt_q + 12'h001;
		end
	end

	// per-unit buffers, active copies, compare and output level
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_unit
			localparam logic [5:0] AL = PDC_A_D0L + 6'(8 * g);
			localparam logic [5:0] AH = PDC_A_D0H + 6'(8 * g);
			pdc_dt_if dti ();
			logic     per_start;
			always_ff @(posedge i_clk) begin
				if (!i_rstn)
					buf_q[g] <= PDC_DUTY_RST;
				else if (wr_go && i_address == AL)
					buf_q[g][7:0] <= i_writedata[7:0];
				else if (wr_go && i_address == AH)
					buf_q[g][13:8] <= i_writedata[5:0];
			end
			// reload at period start, and every clock while disabled, so a period sees one value
			always_ff @(posedge i_clk) begin
				if (!i_rstn)
					act_q[g] <= PDC_DUTY_RST;
				else if (wrap || !ctrl_q[PDC_C_EN])
					act_q[g] <= buf_q[g];
			end
			// count equality plus phase pick; phase bits dropped off 1:1
			assign match[g] = ctrl_q[PDC_C_EN]
				&& (act_q[g][13:2] == cnt_q)
				&& (ps_1to1 ? (ph_q == act_q[g][1:0])
				            : (ph_q == 2'h0));
			assign per_start = ctrl_q[PDC_C_EN] && ph_q == 2'h0
				&& cnt_q == 12'h000;
			// match wins over period start so zero duty stays inactive
			always_ff @(posedge i_clk) begin
				if (!i_rstn)
					act_out_q[g] <= 1'b0;
				else if (!ctrl_q[PDC_C_EN])
					act_out_q[g] <= 1'b0;
				else if (match[g])
					act_out_q[g] <= 1'b0;
				else if (per_start)
					act_out_q[g] <= 1'b1;
			end
			assign dti.raw     = act_out_q[g];
			assign dti.comp_en = ctrl_q[PDC_C_CMP];
			assign dti.dead    = dead_q;
			pdc_deadtime u_dt (
				.i_clk  (i_clk),
				.i_rstn (i_rstn),
				.dt     (dti)
			);
			assign pwm_raw[2*g]   = dti.hi;
			assign pwm_raw[2*g+1] = dti.lo;
			// override bit 2g forces unit g, bit 2g+1 is the high-leg level
			always_ff @(posedge i_clk) begin
				if (!i_rstn) begin
					o_pwm[2*g]   <= 1'b0;
					o_pwm[2*g+1] <= 1'b0;
				end else if (ovr_q[2*g]) begin
					o_pwm[2*g]   <= ovr_q[2*g+1];
					o_pwm[2*g+1] <= ~ovr_q[2*g+1];
				end else begin
					o_pwm[2*g]   <= pwm_raw[2*g];
					o_pwm[2*g+1] <= pwm_raw[2*g+1];
				end
			end
			// per-unit checks; a fall while enabled comes from a match
			match_off_a: assert property (@(posedge i_clk)
				disable iff (!i_rstn)
				match[g] |=> !act_out_q[g])
				else $error("output active after match");
			rise_start_a: assert property (@(posedge i_clk)
				disable iff (!i_rstn)
				$rose(act_out_q[g])
				|-> $past(ph_q) == 2'h0 && $past(cnt_q) == 12'h000)
				else $error("output rose outside period start");
			phase_pick_a: assert property (@(posedge i_clk)
				disable iff (!i_rstn)
				$past(ctrl_q[PDC_C_EN]) && $past(ps_1to1)
				&& $fell(act_out_q[g])
				|-> $past(ph_q) == $past(act_q[g][1:0]))
				else $error("match at wrong phase");
			phase_one_a: assert property (@(posedge i_clk)
				disable iff (!i_rstn)
				$past(ctrl_q[PDC_C_EN]) && !$past(ps_1to1)
				&& $fell(act_out_q[g])
				|-> $past(ph_q) == 2'h0)
				else $error("prescaled match off phase one");
			count_eq_a: assert property (@(posedge i_clk)
				disable iff (!i_rstn)
				$past(ctrl_q[PDC_C_EN]) && $fell(act_out_q[g])
				|-> $past(act_q[g][13:2]) == $past(cnt_q))
				else $error("match without count equality");
			reload_a: assert property (@(posedge i_clk)
				disable iff (!i_rstn)
				wrap |=> act_q[g] == $past(buf_q[g]))
				else $error("duty not reloaded at wrap");
			hold_a: assert property (@(posedge i_clk)
				disable iff (!i_rstn)
				ctrl_q[PDC_C_EN] && !wrap && $past(ctrl_q[PDC_C_EN])
				|=> $stable(act_q[g]) or $past(wrap))
				else $error("active duty changed mid period");
			ovr_force_a: assert property (@(posedge i_clk)
				disable iff (!i_rstn)
				ovr_q[2*g] |=> o_pwm[2*g] == $past(ovr_q[2*g+1]))
				else $error("override not applied");
			pair_excl_a: assert property (@(posedge i_clk)
				disable iff (!i_rstn)
				!(o_pwm[2*g] && o_pwm[2*g+1]))
				else $error("pin pair both high");
		end
	endgenerate

	// time base and bus handshake checks
	wrap_zero_a: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		wrap |=> cnt_q == 12'h000 && per_q == $past(per_buf_q))
		else $error("time base did not wrap");
	count_step_a: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		tick && !wrap |=> cnt_q == $past(cnt_q) + 12'h001)
		else $error("time base skipped a count");
	per_hold_a: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		ctrl_q[PDC_C_EN] && !wrap |=> $stable(per_q))
		else $error("period changed mid period");
	wait_one_a: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		!o_waitrequest |=> o_waitrequest)
		else $error("waitrequest low for two cycles");
	answer_due_a: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		st_q == PDC_S_RESP |=> !o_waitrequest)
		else $error("answer cycle missed");
endmodule : pdc_compare
`default_nettype wire

// [pdc_pkg.sv]
// Purpose: shared constants for the duty-cycle compare stage
// Assumes: 32-bit Avalon-MM word registers, byte addresses below
// Notes:   all offsets are word aligned
package pdc_pkg;
	localparam int PDC_NCH = 3;
	localparam int PDC_DW  = 14;
	localparam int PDC_TW  = 12;
	// register byte addresses
	localparam logic [5:0] PDC_A_D0L  = 6'h00;
	localparam logic [5:0] PDC_A_D0H  = 6'h04;
	localparam logic [5:0] PDC_A_D1L  = 6'h08;
	localparam logic [5:0] PDC_A_D1H  = 6'h0C;
	localparam logic [5:0] PDC_A_D2L  = 6'h10;
	localparam logic [5:0] PDC_A_D2H  = 6'h14;
	localparam logic [5:0] PDC_A_PERL = 6'h18;
	localparam logic [5:0] PDC_A_PERH = 6'h1C;
	localparam logic [5:0] PDC_A_CTRL = 6'h20;
	localparam logic [5:0] PDC_A_OVR  = 6'h24;
	localparam logic [5:0] PDC_A_STAT = 6'h28;
	localparam logic [5:0] PDC_A_DEAD = 6'h2C;
	// ctrl fields
	localparam int PDC_C_EN   = 0;
	localparam int PDC_C_MODE = 1;  // 2 bits: 00 free, 01 single
	localparam int PDC_C_PS   = 3;  // 2 bits prescale select
	localparam int PDC_C_CMP  = 5;  // complementary enable
	// reset values
	localparam logic [PDC_DW-1:0] PDC_DUTY_RST = 14'h0000;
	localparam logic [PDC_TW-1:0] PDC_PER_RST  = 12'hFFF;
	localparam logic [7:0]        PDC_DEAD_RST = 8'h04;
	localparam logic [31:0]       PDC_UNMAPPED = 32'h00000000;
	localparam logic [1:0]        PDC_PS_1TO1  = 2'h0;
	localparam logic [1:0]        PDC_M_FREE   = 2'h0;
	localparam logic [1:0]        PDC_M_SINGLE = 2'h1;
	typedef enum logic [2:0] {
		PDC_S_IDLE = 3'b001,
		PDC_S_RESP = 3'b010,
		PDC_S_DONE = 3'b100
	} pdc_bus_t;
endpackage : pdc_pkg

// [pdc_dt_if.sv]
// Purpose: carries one compare result to its dead-time shaper
// Assumes: single clock domain
// Notes:   raw is the comparator level, hi/lo are the shaped pair
`timescale 1ns/1ns
`default_nettype none
interface pdc_dt_if;
	logic       raw;
	logic       comp_en;
	logic [7:0] dead;
	logic       hi;
	logic       lo;
	modport src (output raw, output comp_en, output dead,
		input hi, input lo);
	modport sink (input raw, input comp_en, input dead,
		output hi, output lo);
endinterface : pdc_dt_if
`default_nettype wire

// [pdc_deadtime.sv]
// Purpose: complementary pair with dead time for one compare unit
// Assumes: dead count given in clock cycles, at least one
// Notes:   both outputs low while the dead counter runs
`timescale 1ns/1ns
`default_nettype none
module pdc_deadtime (
	input  wire logic i_clk,
	input  wire logic i_rstn,
	pdc_dt_if.sink    dt
);
	logic       prev_q;
	logic [7:0] cnt_q;
	logic       hi_q;
	logic       lo_q;
	assign dt.hi = hi_q;
	assign dt.lo = lo_q;
	// an edge of raw drops both legs and waits the dead count
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			prev_q <= 1'b0;
			cnt_q  <= 8'h00;
			hi_q   <= 1'b0;
			lo_q   <= 1'b0;
		end else if (!dt.comp_en) begin
			prev_q <= dt.raw;
			cnt_q  <= 8'h00;
			hi_q   <= dt.raw;
			lo_q   <= 1'b0;
		end else if (dt.raw != prev_q) begin
			prev_q <= dt.raw;
			cnt_q  <= dt.dead;
			hi_q   <= 1'b0;
			lo_q   <= 1'b0;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end else begin
			hi_q <= prev_q;
			lo_q <= ~prev_q;
		end
	end
	no_overlap_a: assert property (@(posedge i_clk)
		disable iff (!i_rstn)
		!(hi_q && lo_q)) else $error("pair both active");
endmodule : pdc_deadtime
`default_nettype wire

// [pdc_compare_tb.sv]
// Purpose: self-checking bench for the duty-cycle compare stage
// Assumes: period 15, dead time left at its reset value of 4 clocks
// Notes:   widths counted over 512 clocks, one whole 1:8 period
`timescale 1ns/1ns
`default_nettype none
module pdc_compare_tb
	import pdc_pkg::*;
;
	logic        i_clk       = 1'b0;
	logic        i_rstn      = 1'b0;
	logic [5:0]  i_address   = 6'h00;
	logic        i_read      = 1'b0;
	logic        i_write     = 1'b0;
	logic [31:0] i_writedata = 32'h00000000;
	logic [31:0] o_readdata;
	logic        o_waitrequest;
	logic [5:0]  o_pwm;
	logic [31:0] rd;
	int          err_count       = 0;
	int          samples_checked = 0;
	int          h0;
	int          h1;
	int          both;
	// one row: prescale, duty low, duty high, high clocks in 512
	typedef struct packed {
		logic [1:0] ps;
		logic [7:0] lo;
		logic [7:0] hi;
		int         exp;
	} pdc_row_t;
	// high bits C0 of the high byte must not reach the duty value
	pdc_row_t rows [6] = '{
		'{2'h0, 8'h10, 8'h00, 128},
		'{2'h0, 8'h11, 8'h00, 136},
		'{2'h0, 8'h12, 8'h00, 144},
		'{2'h0, 8'h13, 8'hC0, 152},
		'{2'h1, 8'h13, 8'h00, 128},
		'{2'h2, 8'h11, 8'h00, 128}
	};

	pdc_compare pdc_compare_i (
		.i_clk         (i_clk),
		.i_rstn        (i_rstn),
		.i_address     (i_address),
		.i_read        (i_read),
		.i_write       (i_write),
		.i_writedata   (i_writedata),
		.o_readdata    (o_readdata),
		.o_waitrequest (o_waitrequest),
		.o_pwm         (o_pwm)
	);

	// 25 MHz clock
	always #20 i_clk = ~i_clk;

	task automatic summarize;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// one Avalon cycle; the request stands until the rising edge that
	// samples waitrequest low, and read data is taken at that edge
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		i_address   <= a;
		i_writedata <= d;
		i_write     <= wr;
		i_read      <= !wr;
		@(posedge i_clk);
		while (o_waitrequest !== 1'b0 && n < 20) begin
			n++;
			@(posedge i_clk);
		end
		rd = o_readdata;
		i_write <= 1'b0;
		i_read  <= 1'b0;
		if (o_waitrequest !== 1'b0) begin
			err_count++;
			$display("ERROR waitrequest expected 0 seen 1");
			summarize();
		end
	endtask : bus

	// count high clocks of unit 0 legs over one 512-clock window
	task automatic measure;
		h0 = 0;
		h1 = 0;
		both = 0;
		repeat (512) begin
			@(negedge i_clk);
			h0 += int'(o_pwm[0] === 1'b1);
			h1 += int'(o_pwm[1] === 1'b1);
			both += int'(o_pwm[1:0] === 2'b11);
		end
	endtask : measure

	initial begin
		repeat (6) @(posedge i_clk);
		chk("pwm in reset", 32'h0, {26'h0, o_pwm});
		chk("wait in reset", 32'h1, {31'h0, o_waitrequest});
		i_rstn <= 1'b1;
		bus(1'b1, PDC_A_PERL, 32'h0000000F);
		bus(1'b1, PDC_A_PERH, 32'h00000000);
		bus(1'b1, PDC_A_D0L, 32'h00000010);
		bus(1'b1, PDC_A_D0H, 32'h00000000);
		bus(1'b0, PDC_A_D0L, 32'h00000000);
		chk("duty low", 32'h00000010, rd);
		bus(1'b0, 6'h30, 32'h00000000);
		chk("unmapped", PDC_UNMAPPED, rd);
		// only six bits of a high byte belong to the duty value
		bus(1'b1, PDC_A_D2H, 32'h000000FF);
		bus(1'b0, PDC_A_D2H, 32'h00000000);
		chk("duty high six bits", 32'h0000003F, rd);
		bus(1'b1, PDC_A_D2H, 32'h00000000);
		// enable; the period written while idle is already active
		bus(1'b1, PDC_A_CTRL, 32'h00000001);
		repeat (600) @(posedge i_clk);
		// new prescale takes hold at once, new duty loads at a period start, then measure
		foreach (rows[k]) begin
			bus(1'b1, PDC_A_CTRL, 32'h1 | (32'(rows[k].ps) << PDC_C_PS));
			bus(1'b1, PDC_A_D0L, {24'h0, rows[k].lo});
			bus(1'b1, PDC_A_D0H, {24'h0, rows[k].hi});
			repeat (1100) @(posedge i_clk);
			measure();
			chk("high leg", rows[k].exp, 32'(h0));
		end
		// complementary at 1:1, duty 16: both legs rest for the dead count
		// plus the clock that sees the edge, so each leg loses 5 clocks
		bus(1'b1, PDC_A_CTRL, 32'h1 | (32'h1 << PDC_C_CMP));
		bus(1'b1, PDC_A_D0L, 32'h00000010);
		repeat (1100) @(posedge i_clk);
		measure();
		chk("comp high", 32'd88, 32'(h0));
		chk("comp low", 32'd344, 32'(h1));
		chk("comp overlap", 32'd0, 32'(both));
		// units 1 and 2 hold duty zero: high leg off, low leg on
		chk("idle units", 32'hA, {28'h0, o_pwm[5:2]});
		// override forces the pair whatever the compare says
		bus(1'b1, PDC_A_OVR, 32'h00000003);
		repeat (8) @(posedge i_clk);
		@(negedge i_clk);
		chk("override hi", 32'h1, {30'h0, o_pwm[1:0]});
		bus(1'b1, PDC_A_OVR, 32'h00000001);
		repeat (8) @(posedge i_clk);
		@(negedge i_clk);
		chk("override lo", 32'h2, {30'h0, o_pwm[1:0]});
		// second reset in mid-run
		@(posedge i_clk);
		i_rstn <= 1'b0;
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		chk("pwm rereset", 32'h0, {26'h0, o_pwm});
		chk("wait rereset", 32'h1, {31'h0, o_waitrequest});
		@(posedge i_clk);
		i_rstn <= 1'b1;
		bus(1'b0, PDC_A_D0L, 32'h00000000);
		chk("duty reset", {24'h0, PDC_DUTY_RST[7:0]}, rd);
		summarize();
	end
endmodule : pdc_compare_tb
`default_nettype wire
